// ---- rcb_defs.svh ----
`ifndef RCB_DEFS_SVH
`define RCB_DEFS_SVH

// register byte offsets
`define OFS_CONFIG      12'h000
`define OFS_STATUS      12'h004
`define OFS_HOSTCTRL    12'h008
`define OFS_MEMADDR     12'h00C
`define OFS_MEMDATA     12'h010

// host control fields
`define HC_IRQ_BIT      0

// edges the strap synchroniser needs to fill after release
`define CFG_SETTLE      2'h2

// status fields
`define ST_STALL_BIT    0
`define ST_LOCKED_BIT   1
`define ST_DONE_BIT     2
`define ST_ENDIAN_BIT   3
`define ST_PCI_BIT      4
`define ST_DBGLAT_BIT   5
`define ST_BOOT_LSB     8
`define ST_PLL_LSB      12
`define ST_DBG_LSB      16

// boot mode codes
`define BOOT_NONE       2'h0
`define BOOT_HOST       2'h1
`define BOOT_ROM        2'h2

// pll factor codes
`define PLL_BYPASS      2'h0
`define PLL_X6          2'h1
`define PLL_X12         2'h2
`define PLL_RSVD        2'h3

// rom copy
`define ROM_COPY_BYTES  1024
`define ROM_BASE_ADDR   32'h0000_0000
`define CPU_START_ADDR  32'h0000_0000

// lock time, typical figure in microseconds, worst is +150 percent
`define LOCK_TYP_US     75
`define LOCK_MAX_PCT    250
`define CLK_MHZ         40
`define LOCK_CYCLES     ((`LOCK_TYP_US * `LOCK_MAX_PCT * `CLK_MHZ + 99) / 100)

`endif

// ---- rcb_pkg.sv ----
package rcb_pkg;
    typedef enum logic [2:0] {
        ST_RESET    = 3'b000,
        ST_LOCK     = 3'b001,
        ST_HOSTWAIT = 3'b010,
        ST_ROMCOPY  = 3'b011,
        ST_SDRAM    = 3'b100,
        ST_RUN      = 3'b101
    } boot_state_e;
endpackage : rcb_pkg

// ---- reset_clock_boot_control.sv ----
`timescale 1ns/1ps
`include "rcb_defs.svh"
module reset_clock_boot_control #(
    parameter int LOCK_CYCLES = `LOCK_CYCLES
) (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        ref_clock_in,
    input  wire logic        pll_clock_in,
    input  wire logic        pll_factor_sel_hi,
    input  wire logic        pll_factor_sel_lo,
    input  wire logic [1:0]  boot_mode_sel,
    input  wire logic        pci_host_sel,
    input  wire logic        endian_strap,
    input  wire logic        test_resetn_in,
    input  wire logic        test_resetn_driven,
    input  wire logic        debug_mode_sel_1,
    input  wire logic        debug_mode_sel_0,
    input  wire logic        sdram_present,
    input  wire logic        sdram_init_done,
    input  wire logic        cpu_clear_irq,
    input  wire logic [7:0]  rom_data,
    input  wire logic        rom_valid,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             cpu_clock,
    output logic             pll_enable,
    output logic             cpu_stall,
    output logic [31:0]      cpu_start_addr,
    output logic             cpu_start,
    output logic             emu_resetn,
    output logic [1:0]       debug_mode,
    output logic             host_via_pci,
    output logic             little_endian,
    output logic [31:0]      rom_addr,
    output logic             rom_read,
    output logic [31:0]      mem_addr,
    output logic [31:0]      mem_wdata,
    output logic             mem_write,
    output logic             mem_read,
    input  wire logic [31:0] mem_rdata
);
    localparam logic [31:0] LOCK_CNT = 32'(LOCK_CYCLES);

    typedef struct packed {
        rcb_pkg::boot_state_e state;
        logic        cfgTaken;
        logic [1:0]  cfgWait;
        logic [1:0]  bootMode;
        logic [1:0]  pllSel;
        logic        pci;
        logic        endian;
        logic [31:0] lockCnt;
        logic        locked;
        logic        irqBit;
        logic        irqArmed;
        logic        startPulse;
        logic        trstPrev;
        logic        dbgLatched;
        logic [1:0]  dbgMode;
        logic [31:0] memAddr;
        logic [31:0] memData;
        logic        memWr;
        logic        memRd;
        logic [31:0] rdData;
    } ctl_s;
    ctl_s r;
    ctl_s next_r;

    logic [9:0]  syncOut;
    logic        romStart;
    logic        romDone;
    logic [31:0] pWrAddr;
    logic [31:0] pWrData;
    logic        pWrValid;

    strap_sync #(.WIDTH(10)) u_sync (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .async_in ({pll_factor_sel_hi, pll_factor_sel_lo, boot_mode_sel, pci_host_sel, endian_strap,
                    test_resetn_driven, test_resetn_in, debug_mode_sel_1, debug_mode_sel_0}),
        .sync_out (syncOut)
    );

    wire [1:0] sPll  = syncOut[9:8];
    wire [1:0] sBoot = syncOut[7:6];
    wire       sPci  = syncOut[5];
    wire       sEnd  = syncOut[4];
    // undriven test reset reads as asserted
    wire       sTrst = syncOut[3] & syncOut[2];
    wire [1:0] sDbg  = syncOut[1:0];

    assign romStart = (r.state == rcb_pkg::ST_ROMCOPY);

    rom_packer u_pack (
        .ref_clk      (ref_clk),
        .resetn       (resetn),
        .start        (romStart),
        .littleEndian (r.endian),
        .romData      (rom_data),
        .romValid     (rom_valid),
        .romAddr      (rom_addr),
        .romRead      (rom_read),
        .wrAddr       (pWrAddr),
        .wrData       (pWrData),
        .wrValid      (pWrValid),
        .done         (romDone)
    );

    function automatic logic multMode(input logic [1:0] sel);
        return (sel == `PLL_X6) || (sel == `PLL_X12);
    endfunction : multMode

    wire apbAcc = psel && penable;
    wire apbWr  = apbAcc && pwrite;
    wire apbRd  = apbAcc && !pwrite;
    wire hostMode = (r.bootMode == `BOOT_HOST);
    wire stalled  = (r.state != rcb_pkg::ST_RUN);
    wire hostSet  = apbWr && (paddr == `OFS_HOSTCTRL) && pwdata[`HC_IRQ_BIT];

    always_comb begin
        next_r            = r;
        next_r.startPulse = 1'b0;
        next_r.memWr      = 1'b0;
        next_r.memRd      = 1'b0;
        next_r.trstPrev   = sTrst;
        if (!r.cfgTaken && r.cfgWait != `CFG_SETTLE) begin
            next_r.cfgWait = r.cfgWait + 2'h1;
        end
        // straps taken once, after the synchroniser has filled
        if (!r.cfgTaken && r.cfgWait == `CFG_SETTLE) begin
            next_r.cfgTaken = 1'b1;
            next_r.bootMode = sBoot;
            next_r.pllSel   = sPll;
            next_r.pci      = sPci;
            next_r.endian   = sEnd;
            next_r.trstPrev = sTrst;
        end
        // test reset rise after device reset release
        if (r.cfgTaken && sTrst && !r.trstPrev) begin
            next_r.dbgMode    = sDbg;
            next_r.dbgLatched = 1'b1;
        end
        if (!sTrst) begin
            next_r.dbgLatched = 1'b0;
        end
        if (r.state == rcb_pkg::ST_LOCK && !r.locked) begin
            next_r.lockCnt = r.lockCnt + 32'h1;
            if (r.lockCnt >= LOCK_CNT - 32'h1) begin
                next_r.locked = 1'b1;
            end
        end
        // host irq bit: set ignored until cleared, set wins over clear
        if (cpu_clear_irq && !stalled) begin
            next_r.irqBit   = 1'b0;
            next_r.irqArmed = 1'b1;
        end
        if (hostSet && r.irqArmed) begin
            next_r.irqBit   = 1'b1;
            next_r.irqArmed = 1'b0;
        end
        // host memory access path
        if (apbWr && paddr == `OFS_MEMADDR) begin
            next_r.memAddr = pwdata;
        end
        if (apbWr && paddr == `OFS_MEMDATA && hostMode) begin
            next_r.memData = pwdata;
            next_r.memWr   = 1'b1;
        end
        if (apbRd && paddr == `OFS_MEMDATA && hostMode) begin
            next_r.memRd = 1'b1;
        end
        if (pWrValid) begin
            next_r.memAddr = pWrAddr;
            next_r.memData = pWrData;
            next_r.memWr   = 1'b1;
        end
        unique case (r.state)
            rcb_pkg::ST_RESET: begin
                if (r.cfgTaken) begin
                    next_r.state = multMode(r.pllSel) ? rcb_pkg::ST_LOCK : rcb_pkg::ST_HOSTWAIT;
                    next_r.locked = !multMode(r.pllSel);
                    if (!multMode(r.pllSel)) begin
                        next_r.state = (r.bootMode == `BOOT_HOST) ? rcb_pkg::ST_HOSTWAIT :
                                       (r.bootMode == `BOOT_ROM)  ? rcb_pkg::ST_ROMCOPY  :
                                                                    rcb_pkg::ST_SDRAM;
                    end
                end
            end
            rcb_pkg::ST_LOCK: begin
                if (r.locked) begin
                    next_r.state = (r.bootMode == `BOOT_HOST) ? rcb_pkg::ST_HOSTWAIT :
                                   (r.bootMode == `BOOT_ROM)  ? rcb_pkg::ST_ROMCOPY  :
                                                                rcb_pkg::ST_SDRAM;
                end
            end
            rcb_pkg::ST_HOSTWAIT: begin
                // host irq frees the stall only in host boot
                if (hostMode && hostSet && r.irqArmed) begin
                    next_r.state      = rcb_pkg::ST_RUN;
                    next_r.startPulse = 1'b1;
                end
            end
            rcb_pkg::ST_ROMCOPY: begin
                // last word must reach memory before release
                if (romDone && !pWrValid) begin
                    next_r.state      = rcb_pkg::ST_RUN;
                    next_r.startPulse = 1'b1;
                end
            end
            rcb_pkg::ST_SDRAM: begin
                if (!sdram_present || sdram_init_done) begin
                    next_r.state      = rcb_pkg::ST_RUN;
                    next_r.startPulse = 1'b1;
                end
            end
            rcb_pkg::ST_RUN: begin
            end
            default: begin
                next_r.state = rcb_pkg::ST_RESET;
            end
        endcase
        next_r.rdData = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                `OFS_CONFIG:   next_r.rdData = {26'h0, r.pllSel, r.bootMode, r.pci, r.endian};
                `OFS_STATUS:   next_r.rdData = {14'h0, r.dbgMode, 2'h0, r.pllSel, 2'h0, r.bootMode,
                                               2'h0, r.dbgLatched, r.pci, r.endian,
                                               (r.state == rcb_pkg::ST_RUN), r.locked, stalled};
                `OFS_HOSTCTRL: next_r.rdData = {31'h0, r.irqBit};
                `OFS_MEMADDR:  next_r.rdData = r.memAddr;
                default:       next_r.rdData = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            r          <= '0;
            r.irqArmed <= 1'b1;
            r.endian   <= 1'b1;
            r.state    <= rcb_pkg::ST_RESET;
        end else begin
            r <= next_r;
        end
    end

    wire validAddr = (paddr == `OFS_CONFIG) || (paddr == `OFS_STATUS) || (paddr == `OFS_HOSTCTRL) ||
                     (paddr == `OFS_MEMADDR) || (paddr == `OFS_MEMDATA);
    assign pready  = 1'b1;
    assign pslverr = apbAcc && !validAddr;
    assign prdata  = (paddr == `OFS_MEMDATA) ? mem_rdata : r.rdData;

    assign cpu_clock      = (r.pllSel == `PLL_BYPASS) ? ref_clock_in : pll_clock_in;
    assign pll_enable     = multMode(r.pllSel);
    assign cpu_stall      = stalled;
    assign cpu_start_addr = `CPU_START_ADDR;
    assign cpu_start      = r.startPulse;
    assign emu_resetn     = sTrst;
    assign debug_mode     = r.dbgMode;
    assign host_via_pci   = r.pci;
    assign little_endian  = r.endian;
    assign mem_addr       = r.memAddr;
    assign mem_wdata      = r.memData;
    assign mem_write      = r.memWr;
    assign mem_read       = r.memRd;

    a_stall_until_lock: assert property (@(posedge ref_clk) disable iff (!resetn)
        (!r.locked) |-> cpu_stall) else $error("stall released before lock");
    a_start_pulse: assert property (@(posedge ref_clk) disable iff (!resetn)
        cpu_start |=> !cpu_start && !cpu_stall) else $error("start not single");
    a_host_release: assert property (@(posedge ref_clk) disable iff (!resetn)
        (r.state == rcb_pkg::ST_HOSTWAIT && hostSet && r.irqArmed) |=> !cpu_stall)
        else $error("host irq did not release");
    a_irq_blocked: assert property (@(posedge ref_clk) disable iff (!resetn)
        (!r.irqArmed && !cpu_clear_irq) |=> !r.irqArmed) else $error("irq rearmed early");
    a_rom_release: assert property (@(posedge ref_clk) disable iff (!resetn)
        (r.state == rcb_pkg::ST_ROMCOPY && romDone && !pWrValid) |=> cpu_start)
        else $error("rom done no start");
    a_sdram_wait: assert property (@(posedge ref_clk) disable iff (!resetn)
        (r.state == rcb_pkg::ST_SDRAM && sdram_present && !sdram_init_done) |=> cpu_stall)
        else $error("ran before sdram init");
    a_cfg_static: assert property (@(posedge ref_clk) disable iff (!resetn)
        r.cfgTaken |=> $stable(r.bootMode) && $stable(r.pllSel)) else $error("config changed");
    a_dbg_latch: assert property (@(posedge ref_clk) disable iff (!resetn)
        (r.cfgTaken && sTrst && !r.trstPrev) |=> debug_mode == $past(sDbg)) else $error("debug not latched");
endmodule : reset_clock_boot_control

// ---- rom_boot_model.sv ----
`timescale 1ns/1ps
module rom_boot_model #(
    parameter int LAT = 1
) (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        rom_read,
    input  wire logic [31:0] rom_addr,
    output logic      [7:0]  rom_data,
    output logic             rom_valid
);
    logic [31:0] lastAddr;
    logic        served;
    int          waitCnt;

    // one answer per new address; bus shows inverted data while idle
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            served <= 1'b0;
            waitCnt <= 0;
            rom_valid <= 1'b0;
            rom_data <= 8'h00;
            lastAddr <= 32'h0000_0000;
        end else begin
            rom_valid <= 1'b0;
            rom_data <= ~rom_data;
            if (rom_read && !(served && rom_addr == lastAddr)) begin
                if (waitCnt < LAT) begin
                    waitCnt <= waitCnt + 1;
                end else begin
                    waitCnt <= 0;
                    served <= 1'b1;
                    lastAddr <= rom_addr;
                    rom_valid <= 1'b1;
                    rom_data <= 8'(rom_addr[7:0] * 8'h03 + rom_addr[9:8]);
                end
            end else begin
                waitCnt <= 0;
            end
        end
    end
endmodule : rom_boot_model

// ---- rom_packer.sv ----
`timescale 1ns/1ps
`include "rcb_defs.svh"
module rom_packer (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        start,
    input  wire logic        littleEndian,
    input  wire logic [7:0]  romData,
    input  wire logic        romValid,
    output logic [31:0]      romAddr,
    output logic             romRead,
    output logic [31:0]      wrAddr,
    output logic [31:0]      wrData,
    output logic             wrValid,
    output logic             done
);
    typedef struct packed {
        logic        busy;
        logic        rd;
        logic [10:0] cnt;
        logic [31:0] word;
        logic [31:0] wAddr;
        logic        wValid;
        logic        fin;
    } pack_s;
    pack_s r;
    pack_s next_r;

    always_comb begin
        next_r        = r;
        next_r.wValid = 1'b0;
        if (start && !r.busy && !r.fin) begin
            next_r.busy = 1'b1;
            next_r.rd   = 1'b1;
            next_r.cnt  = '0;
        end else if (r.busy && romValid) begin
            // pack bytes in system endian order
            if (littleEndian) begin
                next_r.word = {romData, r.word[31:8]};
            end else begin
                next_r.word = {r.word[23:0], romData};
            end
            if (r.cnt[1:0] == 2'h3) begin
                next_r.wValid = 1'b1;
                next_r.wAddr  = `CPU_START_ADDR + {21'h0, r.cnt[10:2], 2'h0};
            end
            next_r.cnt = r.cnt + 11'h001;
            if (r.cnt == 11'(`ROM_COPY_BYTES - 1)) begin
                next_r.busy = 1'b0;
                next_r.rd   = 1'b0;
                next_r.fin  = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign romAddr = `ROM_BASE_ADDR + {21'h0, r.cnt};
    assign romRead = r.rd;
    assign wrAddr  = r.wAddr;
    assign wrData  = r.word;
    assign wrValid = r.wValid;
    assign done    = r.fin;
endmodule : rom_packer

// ---- strap_sync.sv ----
`timescale 1ns/1ps
module strap_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_s;
    sync_s r;
    sync_s next_r;

    always_comb begin
        next_r        = r;
        next_r.first  = async_in;
        next_r.second = r.first;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign sync_out = r.second;
endmodule : strap_sync

// ---- tb.sv ----
`timescale 1ns/1ps
`include "rcb_defs.svh"
module tb;
    localparam int LOCK = 10;
    typedef struct {logic [1:0] fs; logic e; logic p; logic pll;} row_s;
    logic        ref_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        refIn = 1'b0, pllIn = 1'b0, selHi = 1'b0, selLo = 1'b0, pci = 1'b0, endian = 1'b1;
    logic [1:0]  boot = 2'h0, dbgSel = 2'h0, dbgMode;
    logic        testResetn = 1'b1, trstDrv = 1'b0, sdram = 1'b0, sdramDone = 1'b0, cpuClr = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, memRd = 32'h0, prdata, romAddr, memAddr, memWd, startAddr, rdv;
    logic        pready, pslverr, cpuClk, pllEn, stall, start, emuResetn, viaPci, little;
    logic        romRd, memWr, memRdEn, romValid, err, romChk = 1'b0;
    logic [7:0]  romData;
    logic [31:0] memArr [16];
    int          bad_count = 0, cmp_count = 0, wIdx = 0;
    row_s        rows [3] = '{'{2'b00, 1'b1, 1'b0, 1'b0}, '{2'b01, 1'b0, 1'b1, 1'b1}, '{2'b10, 1'b1, 1'b1, 1'b1}};

    always #12.5 ref_clk = ~ref_clk;
    always #10 refIn = ~refIn;
    always #3 pllIn = ~pllIn;

    reset_clock_boot_control #(.LOCK_CYCLES(LOCK)) dut (
        .ref_clk(ref_clk), .resetn(resetn), .ref_clock_in(refIn), .pll_clock_in(pllIn),
        .pll_factor_sel_hi(selHi), .pll_factor_sel_lo(selLo), .boot_mode_sel(boot), .pci_host_sel(pci),
        .endian_strap(endian), .test_resetn_in(testResetn), .test_resetn_driven(trstDrv),
        .debug_mode_sel_1(dbgSel[1]), .debug_mode_sel_0(dbgSel[0]), .sdram_present(sdram),
        .sdram_init_done(sdramDone), .cpu_clear_irq(cpuClr), .rom_data(romData), .rom_valid(romValid),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cpu_clock(cpuClk), .pll_enable(pllEn), .cpu_stall(stall),
        .cpu_start_addr(startAddr), .cpu_start(start), .emu_resetn(emuResetn), .debug_mode(dbgMode),
        .host_via_pci(viaPci), .little_endian(little), .rom_addr(romAddr), .rom_read(romRd),
        .mem_addr(memAddr), .mem_wdata(memWd), .mem_write(memWr), .mem_read(memRdEn), .mem_rdata(memRd)
    );

    rom_boot_model #(.LAT(1)) rom (
        .ref_clk(ref_clk), .resetn(resetn), .rom_read(romRd), .rom_addr(romAddr),
        .rom_data(romData), .rom_valid(romValid)
    );

    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [31:0] romWord(input int k);
        logic [7:0] b [4];
        for (int i = 0; i < 4; i++) b[i] = 8'((4 * k + i) % 256 * 3 + (4 * k + i) / 256);
        return endian ? {b[3], b[2], b[1], b[0]} : {b[0], b[1], b[2], b[3]};
    endfunction : romWord

    // a small memory behind the host window
    always @(posedge ref_clk) begin
        if (memWr === 1'b1) memArr[memAddr[3:0]] <= memWd;
        memRd <= memArr[memAddr[3:0]];
        if (romChk && memWr === 1'b1) begin
            chk(memAddr, 32'(wIdx * 4));
            chk(memWd, romWord(wIdx));
            wIdx++;
        end
    end

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            bad_count++;
            finish_test();
        end
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic boot_run(input logic [1:0] fs, input logic [1:0] bm, input logic p, input logic e,
                            input logic sd);
        @(posedge ref_clk);
        resetn <= 1'b0;
        {selHi, selLo} <= fs;
        boot <= bm;
        pci <= p;
        endian <= e;
        sdram <= sd;
        sdramDone <= 1'b0;
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        #1;
    endtask : boot_run

    task automatic wait_run(output int c);
        for (c = 0; c < 10000; c++) begin
            if (stall === 1'b0) break;
            @(posedge ref_clk);
            #1;
        end
        if (c == 10000) begin
            bad_count++;
            finish_test();
        end
    endtask : wait_run

    initial begin
        int c;
        repeat (10) @(posedge ref_clk);
        #1;
        chk(stall, 1'b1);
        chk(start, 1'b0);
        chk(little, 1'b1);
        chk(emuResetn, 1'b0);
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            boot_run(rows[i].fs, `BOOT_NONE, rows[i].p, rows[i].e, 1'b0);
            wait_run(c);
            chk(start, 1'b1);
            chk(startAddr, `CPU_START_ADDR);
            if (rows[i].pll) chk(32'(c + 1 >= LOCK), 32'h1);
            chk(pllEn, rows[i].pll);
            chk(emuResetn, 1'b0);
            @(posedge ref_clk);
            pci <= ~pci;
            endian <= ~endian;
            repeat (4) @(posedge ref_clk);
            #1;
            chk(cpuClk, rows[i].pll ? pllIn : refIn);
            chk(little, rows[i].e);
            chk(viaPci, rows[i].p);
            $display("test row %0d done", i);
        end
        @(posedge ref_clk);
        trstDrv <= 1'b1;
        testResetn <= 1'b0;
        dbgSel <= 2'b10;
        repeat (4) @(posedge ref_clk);
        testResetn <= 1'b1;
        repeat (6) @(posedge ref_clk);
        dbgSel <= 2'b01;
        repeat (6) @(posedge ref_clk);
        #1;
        chk(emuResetn, 1'b1);
        chk(dbgMode, 2'b10);
        $display("test debug latch done");
        boot_run(2'b01, `BOOT_HOST, 1'b1, 1'b1, 1'b0);
        repeat (LOCK + 20) @(posedge ref_clk);
        #1;
        chk(stall, 1'b1);
        chk(viaPci, 1'b1);
        apb(1'b1, `OFS_MEMADDR, 32'h0000_0008);
        apb(1'b1, `OFS_MEMDATA, 32'h5A5A_1234);
        apb(1'b0, `OFS_MEMDATA, 32'h0000_0000);
        chk(rdv, 32'h5A5A_1234);
        #1;
        chk(memRdEn, 1'b1);
        apb(1'b0, 12'h020, 32'h0000_0000);
        chk(err, 1'b1);
        apb(1'b1, `OFS_HOSTCTRL, 32'h0000_0001);
        #1;
        chk(stall, 1'b0);
        chk(start, 1'b1);
        apb(1'b0, `OFS_HOSTCTRL, 32'h0000_0000);
        chk(rdv[0], 1'b1);
        chk(start, 1'b0);
        cpuClr <= 1'b1;
        @(posedge ref_clk);
        cpuClr <= 1'b0;
        apb(1'b0, `OFS_HOSTCTRL, 32'h0000_0000);
        chk(rdv[0], 1'b0);
        $display("test host boot done");
        for (int e = 0; e < 2; e++) begin
            wIdx = 0;
            romChk = 1'b1;
            boot_run(2'b00, `BOOT_ROM, 1'b0, 1'(e), 1'b0);
            repeat (4) @(posedge ref_clk);
            apb(1'b1, `OFS_HOSTCTRL, 32'h0000_0001);
            #1;
            chk(stall, 1'b1);
            wait_run(c);
            chk(start, 1'b1);
            chk(startAddr, `CPU_START_ADDR);
            chk(32'(wIdx), 32'(`ROM_COPY_BYTES / 4));
            romChk = 1'b0;
            $display("test rom boot %0d done", e);
        end
        boot_run(2'b00, `BOOT_NONE, 1'b0, 1'b1, 1'b1);
        repeat (40) @(posedge ref_clk);
        #1;
        chk(stall, 1'b1);
        @(posedge ref_clk);
        sdramDone <= 1'b1;
        #1;
        wait_run(c);
        chk(start, 1'b1);
        $display("test sdram wait done");
        finish_test();
    end
endmodule : tb
